/* File: src/serial_port.sv */
// Serial port of the time-code chip: host registers, transmitter, receiver and receive FIFO
`timescale 1ns/1ps
module serial_port (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire serial_pkg::host_req_s host_req,
   input  wire logic                  rx_pin,
   output logic                       tx_pin_r,
   output logic [7:0]                 rdata_r
);
   import serial_pkg::*;

   logic             enabled_r;
   logic [1:0]       rate_r;
   logic             rx_int_r, tx_int_r, overrun_r, framing_r;
   logic [7:0]       hold_r;
   logic             hold_valid_r;
   logic [9:0]       tx_shift_r;
   logic             tx_busy_r;
   logic [3:0]       tx_bits_r;
   logic [DIV_W-1:0] tx_div_r;
   logic             rx_s1_r, rx_s2_r;
   rx_state_e        rx_state_r;
   logic [DIV_W-1:0] rx_div_r;
   logic [2:0]       rx_bits_r;
   logic [7:0]       rx_shift_r;
   logic [7:0]       fifo_mem_r [FIFO_DEPTH];
   logic [1:0]       wptr_r, rptr_r;
   logic [2:0]       fifo_cnt_r;
   logic [14:0]      rx_age_r;
   logic             midi_rate;

   logic cmd_wr, data_wr, data_rd, tx_tick, tx_load, rx_tick, rx_done, rx_push, rx_pop;
   logic [DIV_W-1:0] bit_len;
   logic [7:0]       status;

   function automatic logic [DIV_W-1:0] period_of(input logic [1:0] rate);
      case (rate)
         RATE_TAPE_SLOW: period_of = DIV_W'(BIT_CYC_SLOW - 1);
         RATE_TAPE_FAST: period_of = DIV_W'(BIT_CYC_FAST - 1);
         default:        period_of = DIV_W'(BIT_CYC_MIDI - 1);
      endcase
   endfunction : period_of

   assign cmd_wr  = host_req.wr && host_req.addr == ADDR_CMD_STATUS;
   assign data_wr = host_req.wr && host_req.addr == ADDR_DATA && enabled_r;
   assign data_rd = host_req.rd && host_req.addr == ADDR_DATA;
   assign bit_len = period_of(rate_r);
   assign tx_tick = tx_busy_r && tx_div_r == '0;
   assign tx_load = hold_valid_r && (!tx_busy_r || (tx_tick && tx_bits_r == 4'h0));
   assign rx_tick = rx_div_r == '0;
   assign rx_done = rx_state_r == RX_STOP && rx_tick;
   assign rx_push = rx_done && rx_s2_r && fifo_cnt_r != 3'(FIFO_DEPTH);
   assign rx_pop  = data_rd && fifo_cnt_r != 3'h0;
   assign midi_rate = rate_r != RATE_TAPE_SLOW && rate_r != RATE_TAPE_FAST;
   assign status  = {enabled_r, 1'b0, framing_r, overrun_r, tx_int_r, rx_int_r, rate_r};

   // Command register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         enabled_r <= 1'b0;
         rate_r    <= RST_RATE;
      end else if (cmd_wr) begin
         enabled_r <= host_req.wdata[CMD_ENABLE];
         rate_r    <= host_req.wdata[RATE_LSB +: 2];
      end
   end

   // Read data, registered one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_r <= RST_BYTE;
      end else if (host_req.rd) begin
         rdata_r <= (host_req.addr == ADDR_DATA) ? fifo_mem_r[rptr_r] : status;
      end
   end

   // Interrupt flags; a hardware set wins over a host clear
   always_ff @(posedge clk_sys) begin
      if (rst || !enabled_r) begin
         rx_int_r  <= 1'b0;
         tx_int_r  <= 1'b0;
         overrun_r <= 1'b0;
         framing_r <= 1'b0;
      end else begin
         if (rx_push) rx_int_r <= 1'b1;
         else if (data_rd) rx_int_r <= 1'b0;
         if (tx_load) tx_int_r <= 1'b1;
         else if (data_wr) tx_int_r <= 1'b0;
         if (rx_done && rx_s2_r && !rx_push) overrun_r <= 1'b1;
         else if (cmd_wr) overrun_r <= 1'b0;
         if (rx_done && !rx_s2_r) framing_r <= 1'b1;
         else if (cmd_wr) framing_r <= 1'b0;
      end
   end

   // Transmit holding byte
   always_ff @(posedge clk_sys) begin
      if (rst || !enabled_r) begin
         hold_valid_r <= 1'b0;
         hold_r       <= RST_BYTE;
      end else if (data_wr) begin
         hold_valid_r <= 1'b1;
         hold_r       <= host_req.wdata;
      end else if (tx_load) begin
         hold_valid_r <= 1'b0;
      end
   end

   // Transmit shifter
   always_ff @(posedge clk_sys) begin
      if (rst || !enabled_r) begin
         tx_busy_r  <= 1'b0;
         tx_shift_r <= '1;
         tx_bits_r  <= 4'h0;
         tx_div_r   <= '0;
         tx_pin_r   <= 1'b1;
      end else begin
         tx_pin_r <= tx_shift_r[0];
         if (tx_load) begin
            tx_busy_r  <= 1'b1;
            tx_shift_r <= {1'b1, hold_r, 1'b0};
            tx_bits_r  <= 4'(FRAME_BITS - 1);
            tx_div_r   <= bit_len;
         end else if (tx_tick) begin
            tx_shift_r <= {1'b1, tx_shift_r[9:1]};
            tx_div_r   <= bit_len;
            if (tx_bits_r == 4'h0) tx_busy_r <= 1'b0;
            else tx_bits_r <= tx_bits_r - 4'h1;
         end else if (tx_busy_r) begin
            tx_div_r <= tx_div_r - DIV_W'(1);
         end
      end
   end

   // Receive pin synchroniser
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= rx_pin;
         rx_s2_r <= rx_s1_r;
      end
   end

   // Receiver: sample mid-bit
   always_ff @(posedge clk_sys) begin
      if (rst || !enabled_r) begin
         rx_state_r <= RX_IDLE;
         rx_div_r   <= '0;
         rx_bits_r  <= 3'h0;
         rx_shift_r <= RST_BYTE;
      end else begin
         rx_div_r <= rx_tick ? bit_len : rx_div_r - DIV_W'(1);
         case (rx_state_r)
            RX_IDLE: begin
               if (!rx_s2_r) begin
                  rx_state_r <= RX_START;
                  rx_div_r   <= {1'b0, bit_len[DIV_W-1:1]};
               end
            end
            RX_START: begin
               if (rx_tick) rx_state_r <= rx_s2_r ? RX_IDLE : RX_DATA;
               rx_bits_r <= 3'h0;
            end
            RX_DATA: begin
               if (rx_tick) begin
                  rx_shift_r <= {rx_s2_r, rx_shift_r[7:1]};
                  rx_bits_r  <= rx_bits_r + 3'h1;
                  if (rx_bits_r == 3'h7) rx_state_r <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_tick) rx_state_r <= RX_IDLE;
            end
            default: rx_state_r <= RX_IDLE;
         endcase
      end
   end

   // Receive FIFO
   always_ff @(posedge clk_sys) begin
      if (rst || !enabled_r) begin
         wptr_r     <= 2'h0;
         rptr_r     <= 2'h0;
         fifo_cnt_r <= 3'h0;
      end else begin
         if (rx_push) wptr_r <= wptr_r + 2'h1;
         if (rx_pop) rptr_r <= rptr_r + 2'h1;
         fifo_cnt_r <= fifo_cnt_r + 3'(rx_push) - 3'(rx_pop);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rx_push) fifo_mem_r[wptr_r] <= rx_shift_r;
   end

   // Cycles since the FIFO last left empty; pinned at full scale once off the MIDI rate
   always_ff @(posedge clk_sys) begin
      if (rst || !enabled_r || fifo_cnt_r == 3'h0) begin
         rx_age_r <= 15'h0000;
      end else if (!midi_rate) begin
         rx_age_r <= '1;
      end else if (rx_age_r != '1) begin
         rx_age_r <= rx_age_r + 15'h0001;
      end
   end

   AST_INACTIVE_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
      !enabled_r |=> tx_pin_r && fifo_cnt_r == 3'h0 && !hold_valid_r)
      else $error("port active while disabled");
   AST_RD_DATA_HEAD: assert property (@(posedge clk_sys) disable iff (rst)
      data_rd && fifo_cnt_r != 3'h0 |=> rdata_r == $past(fifo_mem_r[rptr_r]))
      else $error("data read did not return FIFO head");
   AST_BIT_PERIOD: assert property (@(posedge clk_sys) disable iff (rst)
      tx_tick && tx_bits_r != 4'h0 && enabled_r && !cmd_wr |=> tx_div_r == period_of(rate_r))
      else $error("bit period does not match rate");
   AST_FIFO_BOUND: assert property (@(posedge clk_sys) disable iff (rst)
      enabled_r && fifo_cnt_r == 3'(FIFO_DEPTH) && !rx_pop |=> fifo_cnt_r == 3'(FIFO_DEPTH))
      else $error("FIFO count left full without a read");
   AST_MIDI_MARGIN: assert property (@(posedge clk_sys) disable iff (rst)
      midi_rate && rx_done && rx_s2_r && !rx_push |-> rx_age_r >= 15'(RESPONSE_CYC))
      else $error("receive overrun within host response time");
   AST_HOLD_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
      data_wr && tx_busy_r && !tx_load |=> hold_valid_r && hold_r == $past(host_req.wdata))
      else $error("holding byte not captured");
   AST_STATUS_READ: assert property (@(posedge clk_sys) disable iff (rst)
      host_req.rd && host_req.addr == ADDR_CMD_STATUS |=>
      rdata_r[STAT_RX_INT] == $past(rx_int_r) && rdata_r[STAT_TX_INT] == $past(tx_int_r))
      else $error("status does not show flags");
   AST_RX_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      data_rd && !rx_push |=> !rx_int_r)
      else $error("receive flag not cleared by data read");
   AST_TX_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      data_wr && !tx_load |=> !tx_int_r)
      else $error("transmit flag not cleared by data write");
   AST_START_BIT: assert property (@(posedge clk_sys) disable iff (rst)
      tx_load && !cmd_wr |=> ##1 !tx_pin_r)
      else $error("frame did not begin with low start bit");

   COV_RX_BYTE:   cover property (@(posedge clk_sys) disable iff (rst) rx_push);
   COV_FIFO_FULL: cover property (@(posedge clk_sys) disable iff (rst) fifo_cnt_r == 3'(FIFO_DEPTH));
   COV_BACK2BACK: cover property (@(posedge clk_sys) disable iff (rst) tx_busy_r && hold_valid_r);
   COV_OVERRUN:   cover property (@(posedge clk_sys) disable iff (rst) $rose(overrun_r));
endmodule : serial_port

/* File: include/serial_pkg.sv */
// Constants, host request carrier and state types for the serial port
package serial_pkg;
   localparam int CLK_HZ          = 25_000_000;
   localparam int MIDI_HZ         = 31_250;
   localparam int TAPE_SLOW_HZ    = 9_600;
   localparam int TAPE_FAST_HZ    = 38_400;
   localparam int BIT_CYC_MIDI    = CLK_HZ / MIDI_HZ;
   localparam int BIT_CYC_SLOW    = CLK_HZ / TAPE_SLOW_HZ;
   localparam int BIT_CYC_FAST    = CLK_HZ / TAPE_FAST_HZ;
   localparam int RESPONSE_US     = 1000;
   localparam int RESPONSE_CYC    = CLK_HZ / 1_000_000 * RESPONSE_US;
   localparam int FRAME_BITS      = 10;
   localparam int FIFO_DEPTH      = 4;
   localparam int DIV_W           = 12;

   localparam logic [1:0] RATE_MIDI      = 2'h0;
   localparam logic [1:0] RATE_TAPE_SLOW = 2'h1;
   localparam logic [1:0] RATE_TAPE_FAST = 2'h2;

   localparam logic ADDR_CMD_STATUS = 1'h0;
   localparam logic ADDR_DATA       = 1'h1;

   localparam int RATE_LSB       = 0;
   localparam int STAT_RX_INT    = 2;
   localparam int STAT_TX_INT    = 3;
   localparam int STAT_OVERRUN   = 4;
   localparam int STAT_FRAMING   = 5;
   localparam int CMD_ENABLE     = 7;

   localparam logic [1:0] RST_RATE = 2'h0;
   localparam logic [7:0] RST_BYTE = 8'h00;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       addr;
      logic [7:0] wdata;
   } host_req_s;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_e;
endpackage : serial_pkg

/* File: verif/serial_far_end.sv */
// Far-end serial equipment: decodes the transmit line and sends frames into the receiver
`timescale 1ns/1ps
module serial_far_end (
   input  wire logic clk_sys,
   input  wire logic tx_pin,
   output logic      rx_pin
);
   int         bit_cyc  = 800;
   logic [7:0] got_q[$];
   logic       stop_bad = 1'b0;
   logic       stop_val = 1'b1;

   initial rx_pin = 1'b1;

   always begin : rx_decode
      logic [7:0] b;
      @(negedge tx_pin);
      repeat (bit_cyc / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cyc) @(posedge clk_sys);
         b[i] = tx_pin;
      end
      repeat (bit_cyc) @(posedge clk_sys);
      if (tx_pin !== 1'b1) stop_bad = 1'b1;
      got_q.push_back(b);
   end

   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {stop_val, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         #1 rx_pin = f[i];
         repeat (bit_cyc) @(posedge clk_sys);
      end
      #1 rx_pin = 1'b1;
   endtask : send_byte
endmodule : serial_far_end

/* File: verif/timecode_chip_serial_uart_bench.sv */
// Testbench for the serial port: reset, rate select, transmit holding and receive queue
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end
module timecode_chip_serial_uart_bench;
   import serial_pkg::*;
   logic       clk_sys;
   logic       rst;
   host_req_s  host_req;
   logic       rx_pin;
   logic       tx_pin_r;
   logic [7:0] rdata_r;
   logic [7:0] v;
   int         mismatches  = 0;
   int         comparisons = 0;

   serial_port uut (.clk_sys(clk_sys), .rst(rst), .host_req(host_req), .rx_pin(rx_pin), .tx_pin_r(tx_pin_r),
                    .rdata_r(rdata_r));
   serial_far_end far (.clk_sys(clk_sys), .tx_pin(tx_pin_r), .rx_pin(rx_pin));

   task automatic close_out();
      $display("Counts: mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   // One host cycle; a read leaves its answer in v
   task automatic host_op(input logic wr, input logic a, input logic [7:0] d);
      @(posedge clk_sys);
      #1 host_req = '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(posedge clk_sys);
      #1 host_req = '0;
      v = rdata_r;
   endtask : host_op

   task automatic wait_got(input int n, input int lim);
      int i;
      for (i = 0; i < lim && far.got_q.size() < n; i++) @(posedge clk_sys);
      if (i == lim) begin
         mismatches++;
         close_out();
      end
   endtask : wait_got

   task automatic t_reset();
      `CHECK(tx_pin_r, 1'b1)
      `CHECK(rdata_r, 8'h00)
      host_op(1'b1, ADDR_DATA, 8'h5a);
      repeat (2000) @(posedge clk_sys);
      `CHECK(far.got_q.size(), 0)
      host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
      `CHECK(v, 8'h00)
   endtask : t_reset

   task automatic t_rates();
      logic [1:0] code [2] = '{RATE_TAPE_SLOW, RATE_TAPE_FAST};
      int         cyc [2]  = '{BIT_CYC_SLOW, BIT_CYC_FAST};
      logic [7:0] pat [2]  = '{8'h96, 8'h4b};
      for (int k = 0; k < 2; k++) begin
         far.bit_cyc = cyc[k];
         host_op(1'b1, ADDR_CMD_STATUS, {1'h1, 5'h00, code[k]});
         host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
         `CHECK(v & 8'h83, {1'h1, 5'h00, code[k]})
         host_op(1'b1, ADDR_DATA, pat[k]);
         wait_got(k + 1, 12 * cyc[k]);
         `CHECK(far.got_q[k], pat[k])
         repeat (cyc[k]) @(posedge clk_sys);
      end
   endtask : t_rates

   task automatic t_tx_hold();
      far.bit_cyc = BIT_CYC_MIDI;
      host_op(1'b1, ADDR_CMD_STATUS, 8'h80);
      host_op(1'b1, ADDR_DATA, 8'h3c);
      host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
      `CHECK(v[STAT_TX_INT], 1'b1)
      host_op(1'b1, ADDR_DATA, 8'hc3);
      host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
      `CHECK(v[STAT_TX_INT], 1'b0)
      wait_got(4, 21 * BIT_CYC_MIDI);
      `CHECK(far.got_q[2], 8'h3c)
      `CHECK(far.got_q[3], 8'hc3)
      host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
      `CHECK(v[STAT_TX_INT], 1'b1)
   endtask : t_tx_hold

   task automatic t_rx_fifo();
      logic [7:0] pat [5] = '{8'h11, 8'ha2, 8'h5c, 8'he7, 8'h08};
      for (int k = 0; k < 4; k++) far.send_byte(pat[k]);
      // Host answers the first byte a full response time late
      repeat (RESPONSE_CYC - 3 * FRAME_BITS * BIT_CYC_MIDI) @(posedge clk_sys);
      host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
      `CHECK(v & 8'h34, 8'h04)
      far.send_byte(pat[4]);
      host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
      `CHECK(v & 8'h34, 8'h14)
      for (int k = 0; k < 4; k++) begin
         host_op(1'b0, ADDR_DATA, 8'h00);
         `CHECK(v, pat[k])
         host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
         `CHECK(v[STAT_RX_INT], 1'b0)
      end
   endtask : t_rx_fifo

   task automatic t_framing();
      host_op(1'b1, ADDR_CMD_STATUS, 8'h83);
      host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
      `CHECK(v & 8'hf7, 8'h83)
      host_op(1'b1, ADDR_DATA, 8'ha5);
      far.stop_val = 1'b0;
      far.send_byte(8'h6e);
      far.stop_val = 1'b1;
      host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
      `CHECK(v & 8'h34, 8'h20)
      wait_got(5, 12 * BIT_CYC_MIDI);
      `CHECK(far.got_q[4], 8'ha5)
      host_op(1'b1, ADDR_CMD_STATUS, 8'h00);
      host_op(1'b0, ADDR_CMD_STATUS, 8'h00);
      `CHECK(v, 8'h00)
   endtask : t_framing

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      rst = 1'b1;
      host_req = '0;
      repeat (10) @(posedge clk_sys);
      #1 rst = 1'b0;
      t_reset();
      t_rates();
      t_tx_hold();
      t_rx_fifo();
      t_framing();
      `CHECK(far.stop_bad, 1'b0)
      close_out();
   end
endmodule : timecode_chip_serial_uart_bench
